// file: verification/bcr_regs_tb_top.sv
// bcr_regs_tb_top.sv: self-checking bench for the bias control register group
// assumes: design package, header and modules compiled first; 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module bcr_regs_tb_top;
   import bcr_pkg::*;
   // ------------------------------------------------------------
   // design connections
   // ------------------------------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   bcr_cmd_t    cmd = '0;
   logic [15:0] rdata_r;
   logic        rvalid_r;
   bcr_mode_t   mode = BCR_MODE_MSG;
   logic        conv_active = 1'b0;
   logic [11:0] flags = 12'h4a1;         // flag contents shown on empty reads
   bcr_word_t   src_word;
   logic        src_valid;
   logic        src_ready_r;
   logic        fifo_clr = 1'b0;
   logic [11:0] ch1_stage = 12'h5a5;
   logic [11:0] ch2_stage = 12'h3c3;
   logic [11:0] ch1_out_r, ch2_out_r;
   logic        sleep_r, ref_on_r, wdg_run_r, osc_run_r, ch1_en_r, ch2_en_r;
   logic [7:0]  msg_len_r, msg_start_r;
   logic [8:0]  msg_words_r;
   logic [5:0]  pwr;                     // power outputs gathered
   int          bad_count = 0;
   int          check_count = 0;
   logic [15:0] v;
   // shutdown table: written value, converter busy, expected power outputs
   logic [15:0] sd_w [9] = '{16'h0000, 16'h0010, 16'h0000, 16'h0008, 16'h0004,
                             16'h0002, 16'h0001, 16'h0030, 16'hffc0};
   logic        sd_c [9] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   logic [5:0]  sd_e [9] = '{6'h0f, 6'h1f, 6'h1f, 6'h07, 6'h0b, 6'h0e, 6'h0d,
                             6'h20, 6'h0f};
   assign pwr = {sleep_r, ref_on_r, wdg_run_r, osc_run_r, ch1_en_r, ch2_en_r};
   always #12.5 sys_clk = ~sys_clk;
   bcr_regs #(.DEPTH(8)) dut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .rdata_r(rdata_r),
      .rvalid_r(rvalid_r), .mode(mode), .conv_active(conv_active), .flags(flags),
      .src_word(src_word), .src_valid(src_valid), .src_ready_r(src_ready_r),
      .fifo_clr(fifo_clr), .ch1_stage(ch1_stage), .ch2_stage(ch2_stage),
      .ch1_out_r(ch1_out_r), .ch2_out_r(ch2_out_r), .sleep_r(sleep_r), .ref_on_r(ref_on_r),
      .wdg_run_r(wdg_run_r), .osc_run_r(osc_run_r), .ch1_en_r(ch1_en_r),
      .ch2_en_r(ch2_en_r), .msg_len_r(msg_len_r), .msg_start_r(msg_start_r),
      .msg_words_r(msg_words_r));
   bcr_src_model src (.sys_clk(sys_clk), .src_ready_r(src_ready_r), .src_word(src_word),
      .src_valid(src_valid), .stuck());
   // ------------------------------------------------------------
   // compare, access and closing tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // write strobe for one cycle, then two idle cycles
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      cmd = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
      @(negedge sys_clk);
      cmd = '0;
      repeat (2) @(negedge sys_clk);      // power outputs land two cycles on
   endtask
   // read strobe; answer stands in the cycle after the taking edge
   task automatic rd(input logic [7:0] idx, output logic [15:0] r);
      cmd = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 16'h0000};
      @(negedge sys_clk);
      cmd = '0;
      check(16'(rvalid_r), 16'h0001);
      r = rdata_r;
      @(negedge sys_clk);
      check(16'(rvalid_r), 16'h0000);     // strobe lasts one cycle
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // hang guard
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      results();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      check(rdata_r, 16'h0000);
      check(16'(pwr), 16'h000c);
      check(16'(msg_words_r), 16'h0001);
      rd(8'h00, v);
      check(v, 16'h0003);
      rd(8'h02, v);
      check(v, 16'h0000);
      // power control table, unused bits dropped on readback
      for (int i = 0; i < 9; i++) begin
         conv_active = sd_c[i];
         wr(8'h00, sd_w[i]);
         check(16'(pwr), 16'(sd_e[i]));
         rd(8'h00, v);
         check(v, sd_w[i] & 16'h003f);
      end
      conv_active = 1'b0;
      // channel commits copy only the selected channel
      wr(8'h01, 16'h0001);
      check(16'(ch1_out_r), 16'h05a5);
      check(16'(ch2_out_r), 16'h0000);
      wr(8'h01, 16'h0002);
      check(16'(ch2_out_r), 16'h03c3);
      ch1_stage = 12'h111;
      ch2_stage = 12'h222;
      wr(8'h01, 16'hfffc);
      check({ch1_out_r, 4'h0}, 16'h5a50);
      check({ch2_out_r, 4'h0}, 16'h3c30);
      wr(8'h01, 16'h0003);
      check({ch1_out_r, 4'h0}, 16'h1110);
      check({ch2_out_r, 4'h0}, 16'h2220);
      rd(8'h01, v);
      check(v, 16'h0000);
      // message setup with the length field at its maximum
      wr(8'h02, 16'hff12);
      rd(8'h02, v);
      check(v, 16'hff12);
      check({msg_len_r, msg_start_r}, 16'hff12);
      check(16'(msg_words_r), 16'h0100);
      // second reset in mid-run; the stale answer must clear too
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      check(rdata_r, 16'h0000);
      check(16'(pwr), 16'h000c);
      check(16'(ch1_out_r), 16'h0000);
      check(16'(ch2_out_r), 16'h0000);
      check(16'(msg_words_r), 16'h0001);
      rd(8'h02, v);
      check(v, 16'h0000);
      // empty read, then writes to the readout and an unmapped index
      rd(8'h03, v);
      check(v, 16'hf4a1);
      wr(8'h03, 16'h1234);
      wr(8'h07, 16'hffff);
      rd(8'h03, v);
      check(v, 16'hf4a1);
      rd(8'h07, v);
      check(v, 16'h0000);
      rd(8'h00, v);
      check(v, 16'h0003);
      // fill until refused, drain one, refill, drain to empty
      for (int i = 0; i < 8; i++) begin
         mode = bcr_mode_t'(2'(i % 3));
         src.push({4'(i), 12'h5a0 + 12'(i)});
      end
      check(16'(src_ready_r), 16'h0000);
      rd(8'h03, v);
      check(v, 16'h05a0);
      src.push({4'h8, 12'h5a8});
      for (int i = 1; i < 9; i++) begin
         rd(8'h03, v);
         check(v, {4'(i), 12'h5a0 + 12'(i)});
      end
      flags = 12'h0c3;
      rd(8'h03, v);
      check(v, 16'hf0c3);
      // flush drops whatever is queued
      src.push(16'h2abc);
      src.push(16'h2abd);
      fifo_clr = 1'b1;
      @(negedge sys_clk);
      fifo_clr = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd(8'h03, v);
      check(v, 16'hf0c3);
      check(16'(src.stuck), 16'h0000);
      results();
   end
endmodule // bcr_regs_tb_top
`default_nettype wire

// file: verification/bcr_src_model.sv
// bcr_src_model.sv: producer engine stand-in that fills the readout fifo
// assumes: bench calls push from its main sequence, one clock, inputs moved at falling edge
`timescale 1ns/1ps
`default_nettype none
module bcr_src_model (
   input  wire logic          sys_clk,
   input  wire logic          src_ready_r,  // fifo room, one cycle late
   output var bcr_pkg::bcr_word_t src_word,  // word offered
   output logic               src_valid,    // offer strobe
   output int                 stuck         // pushes that never found room
);
   import bcr_pkg::*;
   // ------------------------------------------------------------
   // idle state at time zero
   // ------------------------------------------------------------
   initial begin
      src_word = 16'h0000;
      src_valid = 1'b0;
      stuck = 0;
   end
   // ------------------------------------------------------------
   // one word per call; two idle cycles after each push so the
   // late ready flag has settled before the next offer
   // ------------------------------------------------------------
   task automatic push(input logic [15:0] w);
      int n;
      n = 0;
      while (src_ready_r !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 200) begin
         stuck++;                            // bounded wait ran out
      end else begin
         src_word = w;
         src_valid = 1'b1;
         @(negedge sys_clk);
         src_valid = 1'b0;
         src_word = ~w;                      // released: never a stale copy
         repeat (2) @(negedge sys_clk);
      end
   endtask
endmodule // bcr_src_model
`default_nettype wire

// file: verilog/bcr_cfg.svh
// bcr_cfg.svh: offsets, field positions, reset values for the bias control register group
// assumes: included by bare name from the register design file
//
// Behaviour
// - full sleep bit shuts every section down
// - reference kept on unless full sleep
// - otherwise reference on only during conversion
// - watchdog oscillator stops when bit set
// - main oscillator stops when bit set
// - channel two off while bit set, resets 1
// - channel one off while bit set, resets 1
// - commit bit copies channel two staged code
// - commit bit copies channel one staged code
// - length field plus one words read, resets 0
// - start field sets readback word address
// - top nibble: data, or tag when monitoring
// - low twelve bits data, register resets zero
// - empty read gives all-ones tag plus flags
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
// ------------------------------------------------------------
// register indices on the command port
// ------------------------------------------------------------
`define BCR_IDX_SHUTDOWN   8'h00
`define BCR_IDX_LOAD       8'h01
`define BCR_IDX_MESSAGE    8'h02
`define BCR_IDX_FIFO       8'h03
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BCR_B_SLEEP        5
`define BCR_B_REFON        4
`define BCR_B_WDG          3
`define BCR_B_OSC          2
`define BCR_B_CH2          1
`define BCR_B_CH1          0
`define BCR_SHUT_MASK      16'h003f
`define BCR_SHUT_RESET     16'h0003
`define BCR_MSG_RESET      16'h0000
`define BCR_FIFO_RESET     16'h0000
`define BCR_TAG_EMPTY      4'hf
`define BCR_FIFO_DEPTH     8
`endif

// file: verilog/bcr_fifo.sv
// bcr_fifo.sv: flip-flop fifo with valid/ready on both sides
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module bcr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             clr,        // flush all entries
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   // ------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------
   logic [WIDTH-1:0] mem_r [DEPTH];   // entries
   logic [AW-1:0]    wp_r;            // write index
   logic [AW-1:0]    rp_r;            // read index
   logic [AW:0]      cnt_r;           // occupancy
   logic             push;
   logic             pop;
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0; // room while not full
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   // write side
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
   // pointers; depth assumed a power of two so indices wrap
   always_ff @(posedge sys_clk) begin
      if (rst || clr) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + AW'(1);
         if (pop)  rp_r <= rp_r + AW'(1);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // bcr_fifo
`default_nettype wire

// file: verilog/bcr_pkg.sv
// bcr_pkg.sv: types shared by the register group, its bench and the producer model
// assumes: bcr_cfg.svh on the include path
package bcr_pkg;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BCR_MODE_MSG  = 2'b00,           // message readback
      BCR_MODE_LUT  = 2'b01,           // table streaming
      BCR_MODE_MON  = 2'b10            // converter monitoring
   } bcr_mode_t;
   typedef struct packed {
      logic [3:0]  top;                // data high nibble or channel tag
      logic [11:0] low;                // data or converter result
   } bcr_word_t;
   typedef struct packed {
      logic        wr;                 // write strobe
      logic        rd;                 // read strobe
      logic [7:0]  idx;                // register index
      logic [15:0] wdata;              // write data
   } bcr_cmd_t;
endpackage

// file: verilog/bcr_regs.sv
// bcr_regs.sv: shutdown, converter load, message setup and fifo readout registers
// assumes: a serial front end turns host frames into one-cycle command strobes
`timescale 1ns/1ps
`default_nettype none
`include "bcr_cfg.svh"
module bcr_regs #(
   parameter int DEPTH = `BCR_FIFO_DEPTH   // fifo entries
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire bcr_pkg::bcr_cmd_t cmd,          // decoded register access
   output logic [15:0]            rdata_r,      // read answer, one cycle after rd
   output logic                   rvalid_r,     // read answer strobe
   input  wire bcr_pkg::bcr_mode_t mode,        // current fifo producer mode
   input  wire logic              conv_active,  // converter busy
   input  wire logic [11:0]       flags,        // flag register contents
   input  wire bcr_pkg::bcr_word_t src_word,    // word from producer engine
   input  wire logic              src_valid,
   output logic                   src_ready_r,  // fifo has room
   input  wire logic              fifo_clr,     // flush request
   input  wire logic [11:0]       ch1_stage,    // channel one staged code
   input  wire logic [11:0]       ch2_stage,    // channel two staged code
   output logic [11:0]            ch1_out_r,    // channel one committed code
   output logic [11:0]            ch2_out_r,    // channel two committed code
   output logic                   sleep_r,      // whole device asleep
   output logic                   ref_on_r,     // reference powered
   output logic                   wdg_run_r,    // watchdog osc running
   output logic                   osc_run_r,    // main osc running
   output logic                   ch1_en_r,     // channel one powered
   output logic                   ch2_en_r,     // channel two powered
   output logic [7:0]             msg_len_r,    // words to read minus one
   output logic [7:0]             msg_start_r,  // first word address
   output logic [8:0]             msg_words_r   // words actually read
);
   import bcr_pkg::*;
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic [15:0] shut_r;             // shutdown register, only six bits live
   logic        wr_shut;
   logic        wr_load;
   logic        wr_msg;
   logic        rd_fifo;
   logic        rd_shut;
   logic        rd_msg;
   logic [15:0] fifo_q;             // fifo head
   logic        fifo_v;             // head valid
   logic        fifo_in_rdy;        // room on fill side
   logic [15:0] shut_nxt;
   // address decode as a priority chain, unmapped reads answer zero
   always_comb begin
      wr_shut = 1'b0;
      wr_load = 1'b0;
      wr_msg  = 1'b0;
      rd_shut = 1'b0;
      rd_msg  = 1'b0;
      rd_fifo = 1'b0;
      if (cmd.idx == `BCR_IDX_SHUTDOWN) begin
         wr_shut = cmd.wr;
         rd_shut = cmd.rd;
      end else if (cmd.idx == `BCR_IDX_LOAD) begin
         wr_load = cmd.wr;          // write only, reads give zero
      end else if (cmd.idx == `BCR_IDX_MESSAGE) begin
         wr_msg = cmd.wr;
         rd_msg = cmd.rd;
      end else if (cmd.idx == `BCR_IDX_FIFO) begin
         rd_fifo = cmd.rd;          // read only, writes dropped
      end
   end
   assign shut_nxt = cmd.wdata & `BCR_SHUT_MASK;
   // ------------------------------------------------------------
   // shutdown register
   // ------------------------------------------------------------
   // reset leaves both channels powered down
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shut_r <= `BCR_SHUT_RESET;
      end else if (wr_shut) begin
         shut_r <= shut_nxt;
      end
   end
   // power controls; full sleep overrides every section
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sleep_r   <= 1'b0;
         ref_on_r  <= 1'b0;
         wdg_run_r <= 1'b1;
         osc_run_r <= 1'b1;
         ch1_en_r  <= 1'b0;
         ch2_en_r  <= 1'b0;
      end else begin
         sleep_r   <= shut_r[`BCR_B_SLEEP];
         ref_on_r  <= !shut_r[`BCR_B_SLEEP] &&
                      (shut_r[`BCR_B_REFON] || conv_active);
         wdg_run_r <= !shut_r[`BCR_B_SLEEP] && !shut_r[`BCR_B_WDG];
         osc_run_r <= !shut_r[`BCR_B_SLEEP] && !shut_r[`BCR_B_OSC];
         ch2_en_r  <= !shut_r[`BCR_B_SLEEP] && !shut_r[`BCR_B_CH2];
         ch1_en_r  <= !shut_r[`BCR_B_SLEEP] && !shut_r[`BCR_B_CH1];
      end
   end
   // ------------------------------------------------------------
   // converter load
   // ------------------------------------------------------------
   // commit is a write action only; nothing is stored in the load register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ch1_out_r <= 12'h000;
         ch2_out_r <= 12'h000;
      end else if (wr_load) begin
         if (cmd.wdata[`BCR_B_CH2]) ch2_out_r <= ch2_stage;
         if (cmd.wdata[`BCR_B_CH1]) ch1_out_r <= ch1_stage;
      end
   end
   // ------------------------------------------------------------
   // message setup
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         msg_len_r   <= 8'(`BCR_MSG_RESET >> 8);
         msg_start_r <= 8'(`BCR_MSG_RESET);
         msg_words_r <= 9'h001;
      end else if (wr_msg) begin
         msg_len_r   <= cmd.wdata[15:8];
         msg_start_r <= cmd.wdata[7:0];
         msg_words_r <= {1'b0, cmd.wdata[15:8]} + 9'h001;
      end
   end
   // ------------------------------------------------------------
   // fifo in the data path
   // ------------------------------------------------------------
   // producer's tag already sits in the top nibble when monitoring
   bcr_fifo #(
      .WIDTH (16),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clr       (fifo_clr),
      .in_data   (src_word),
      .in_valid  (src_valid),
      .in_ready  (fifo_in_rdy),
      .out_data  (fifo_q),
      .out_valid (fifo_v),
      .out_ready (rd_fifo)
   );
   // ready registered; a word offered while stale-ready is caught by fifo's own ready
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_ready_r <= 1'b0;
      end else begin
         src_ready_r <= fifo_in_rdy;
      end
   end
   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_r  <= `BCR_FIFO_RESET;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= cmd.rd;
         if (rd_fifo) begin
            if (fifo_v) begin
               rdata_r <= fifo_q;
            end else begin
               rdata_r <= {`BCR_TAG_EMPTY, flags};
            end
         end else if (rd_shut) begin
            rdata_r <= shut_r & `BCR_SHUT_MASK;
         end else if (rd_msg) begin
            rdata_r <= {msg_len_r, msg_start_r};
         end else if (cmd.rd) begin
            rdata_r <= 16'h0000;                       // load and unmapped
         end
      end
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_sleep_all_off;
      @(posedge sys_clk) disable iff (rst)
      sleep_r |-> !osc_run_r && !wdg_run_r && !ch1_en_r && !ch2_en_r && !ref_on_r;
   endproperty
   a_sleep_all_off: assert property (p_sleep_all_off) else $error("section on in sleep");
   property p_ref_keep;
      @(posedge sys_clk) disable iff (rst)
      ##1 ($past(shut_r[`BCR_B_REFON]) && !$past(shut_r[`BCR_B_SLEEP])) |-> ref_on_r;
   endproperty
   a_ref_keep: assert property (p_ref_keep) else $error("reference dropped");
   property p_ref_conv;
      @(posedge sys_clk) disable iff (rst)
      ##1 (!$past(shut_r[`BCR_B_REFON])) |-> (ref_on_r == (!$past(shut_r[`BCR_B_SLEEP]) && $past(conv_active)));
   endproperty
   a_ref_conv: assert property (p_ref_conv) else $error("reference not tied to conversion");
   // one shutdown write that sets the given bit
   sequence s_shut_set(int b);
      wr_shut && cmd.wdata[b];
   endsequence
   // one shutdown write that clears the given bit, full sleep clear too
   sequence s_shut_clr(int b);
      wr_shut && !cmd.wdata[b] && !cmd.wdata[`BCR_B_SLEEP];
   endsequence
   property p_wdg;
      @(posedge sys_clk) disable iff (rst)
      s_shut_set(`BCR_B_WDG) |-> ##2 !wdg_run_r;
   endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog osc not stopped");
   property p_osc;
      @(posedge sys_clk) disable iff (rst)
      s_shut_set(`BCR_B_OSC) |-> ##2 !osc_run_r;
   endproperty
   a_osc: assert property (p_osc) else $error("main osc not stopped");
   property p_ch2_off;
      @(posedge sys_clk) disable iff (rst)
      s_shut_set(`BCR_B_CH2) |-> ##2 !ch2_en_r;
   endproperty
   a_ch2_off: assert property (p_ch2_off) else $error("channel two still on");
   property p_ch1_off;
      @(posedge sys_clk) disable iff (rst)
      s_shut_set(`BCR_B_CH1) |-> ##2 !ch1_en_r;
   endproperty
   a_ch1_off: assert property (p_ch1_off) else $error("channel one still on");
   property p_ch2_commit;
      @(posedge sys_clk) disable iff (rst)
      wr_load && cmd.wdata[`BCR_B_CH2] |=> ch2_out_r == $past(ch2_stage);
   endproperty
   a_ch2_commit: assert property (p_ch2_commit) else $error("channel two not committed");
   property p_ch1_commit;
      @(posedge sys_clk) disable iff (rst)
      wr_load && cmd.wdata[`BCR_B_CH1] |=> ch1_out_r == $past(ch1_stage);
   endproperty
   a_ch1_commit: assert property (p_ch1_commit) else $error("channel one not committed");
   property p_len;
      @(posedge sys_clk) disable iff (rst)
      wr_msg |=> msg_words_r == {1'b0, $past(cmd.wdata[15:8])} + 9'h001;
   endproperty
   a_len: assert property (p_len) else $error("word count wrong");
   property p_start;
      @(posedge sys_clk) disable iff (rst)
      wr_msg |=> msg_start_r == $past(cmd.wdata[7:0]);
   endproperty
   a_start: assert property (p_start) else $error("start address wrong");
   property p_fifo_word;
      @(posedge sys_clk) disable iff (rst)
      rd_fifo && fifo_v |=> rdata_r == $past(fifo_q) && rvalid_r;
   endproperty
   a_fifo_word: assert property (p_fifo_word) else $error("fifo word lost");
   property p_empty;
      @(posedge sys_clk) disable iff (rst)
      rd_fifo && !fifo_v |=> rdata_r == {4'hf, $past(flags)};
   endproperty
   a_empty: assert property (p_empty) else $error("empty tag wrong");
   property p_unused;
      @(posedge sys_clk) disable iff (rst)
      rd_shut |=> rdata_r[15:6] == 10'h000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits nonzero");
   // ------------------------------------------------------------
   // wake checks: a cleared bit brings its section back; shutdown bits hold between writes
   // ------------------------------------------------------------
   // leaving full sleep takes one write with the sleep bit clear
   property p_wake;
      @(posedge sys_clk) disable iff (rst)
      wr_shut && !cmd.wdata[`BCR_B_SLEEP] |-> ##2 !sleep_r;
   endproperty
   a_wake: assert property (p_wake) else $error("sleep not left");
   // bits only move on a shutdown write
   property p_shut_hold;
      @(posedge sys_clk) disable iff (rst)
      !wr_shut |=> $stable(shut_r);
   endproperty
   a_shut_hold: assert property (p_shut_hold) else $error("shutdown bits moved");
   // oscillators restart once their bit is cleared
   property p_wdg_run;
      @(posedge sys_clk) disable iff (rst)
      s_shut_clr(`BCR_B_WDG) |-> ##2 wdg_run_r;
   endproperty
   a_wdg_run: assert property (p_wdg_run) else $error("watchdog osc not restarted");
   property p_osc_run;
      @(posedge sys_clk) disable iff (rst)
      s_shut_clr(`BCR_B_OSC) |-> ##2 osc_run_r;
   endproperty
   a_osc_run: assert property (p_osc_run) else $error("main osc not restarted");
   // a cleared channel bit powers that channel again
   property p_ch2_on;
      @(posedge sys_clk) disable iff (rst)
      s_shut_clr(`BCR_B_CH2) |-> ##2 ch2_en_r;
   endproperty
   a_ch2_on: assert property (p_ch2_on) else $error("channel two not powered");
   property p_ch1_on;
      @(posedge sys_clk) disable iff (rst)
      s_shut_clr(`BCR_B_CH1) |-> ##2 ch1_en_r;
   endproperty
   a_ch1_on: assert property (p_ch1_on) else $error("channel one not powered");
   // ------------------------------------------------------------
   // read side checks
   // ------------------------------------------------------------
   // answer strobe trails the read strobe by one cycle
   property p_rvalid;
      @(posedge sys_clk) disable iff (rst)
      cmd.rd |=> rvalid_r;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   // no answer strobe without a read
   property p_rvalid_idle;
      @(posedge sys_clk) disable iff (rst)
      !cmd.rd |=> !rvalid_r;
   endproperty
   a_rvalid_idle: assert property (p_rvalid_idle) else $error("stray answer strobe");
   // answer stands until the next read; host may sample late
   property p_rdata_hold;
      @(posedge sys_clk) disable iff (rst)
      !cmd.rd |=> $stable(rdata_r);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("answer moved");
   // message readback gives both fields in place
   property p_msg_read;
      @(posedge sys_clk) disable iff (rst)
      rd_msg |=> rdata_r == {$past(msg_len_r), $past(msg_start_r)};
   endproperty
   a_msg_read: assert property (p_msg_read) else $error("message readback wrong");
   // load register stores nothing, so its read gives zero
   property p_load_read;
      @(posedge sys_clk) disable iff (rst)
      cmd.rd && cmd.idx == `BCR_IDX_LOAD |=> rdata_r == 16'h0000;
   endproperty
   a_load_read: assert property (p_load_read) else $error("load read nonzero");
   // ------------------------------------------------------------
   // commit checks
   // ------------------------------------------------------------
   // committed codes move only on a load write with the bit set
   property p_out1_hold;
      @(posedge sys_clk) disable iff (rst)
      !(wr_load && cmd.wdata[`BCR_B_CH1]) |=> $stable(ch1_out_r);
   endproperty
   a_out1_hold: assert property (p_out1_hold) else $error("channel one code moved");
   // one property per channel keeps each failure pointing at one pair
   property p_out2_hold;
      @(posedge sys_clk) disable iff (rst)
      !(wr_load && cmd.wdata[`BCR_B_CH2]) |=> $stable(ch2_out_r);
   endproperty
   a_out2_hold: assert property (p_out2_hold) else $error("channel two code moved");
endmodule // bcr_regs
`default_nettype wire
